// ===== common/spcg_pkg.sv
// Package with register map, field layout and types of the sleep port clock gating block
`default_nettype none
package spcg_pkg;
    // Number of gated port units
    localparam int unsigned NumPorts = 8;
    // APB address width in bits
    localparam int unsigned AddrWidth = 12;
    // Register byte offsets
    localparam logic [11:0] RunGateOffset = 12'h108;
    localparam logic [11:0] SleepGateOffset = 12'h118;
    localparam logic [11:0] DeepGateOffset = 12'h128;
    localparam logic [11:0] ClockCfgOffset = 12'h140;
    localparam logic [11:0] IrqStatusOffset = 12'h144;
    localparam logic [11:0] IrqMaskOffset = 12'h148;
    // Field positions: port A at bit 0 up to port H at bit 7
    localparam int unsigned PortALsb = 0;
    localparam int unsigned PortHMsb = 7;
    // Position of the automatic clock gating flag in the clock configuration register
    localparam int unsigned AutoGateBit = 0;
    // Reset values
    localparam logic [7:0] GateReset = 8'h00;
    localparam logic [7:0] IrqMaskReset = 8'h00;
    localparam logic [7:0] IrqStatusReset = 8'h00;
    localparam logic AutoGateReset = 1'h0;
    localparam logic [31:0] ReadZero = 32'h00000000;

    // System operating mode
    typedef enum logic [1:0] {
        ModeRun = 2'b00,
        ModeSleep = 2'b01,
        ModeDeep = 2'b10
    } spcg_mode_t;

    // Entire state of the top module
    typedef struct packed {
        logic [7:0] runGate;
        logic [7:0] sleepGate;
        logic [7:0] deepGate;
        logic autoGate;
        logic [7:0] irqStatus;
        logic [7:0] irqMask;
        logic [31:0] readData;
        logic slvErr;
        logic [7:0] portClkEn;
        logic [7:0] portFault;
        logic [7:0] portDone;
    } spcg_state_t;
endpackage
`default_nettype wire

// ===== common/spcg_gate_if.sv
// Interface carrying the gating registers and mode to the enable selector
`timescale 1ns/100ps
`default_nettype none
interface spcg_gate_if;
    // Gating registers for each mode
    logic [7:0] runGate;
    logic [7:0] sleepGate;
    logic [7:0] deepGate;
    // Automatic clock gating flag
    logic autoGate;
    // Current system mode
    spcg_pkg::spcg_mode_t mode;
    // Resulting per-port clock enables
    logic [7:0] effEn;

    // Register side
    modport ctrl (
        output runGate,
        output sleepGate,
        output deepGate,
        output autoGate,
        output mode,
        input effEn
    );
    // Selector side
    modport sel (
        input runGate,
        input sleepGate,
        input deepGate,
        input autoGate,
        input mode,
        output effEn
    );
endinterface
`default_nettype wire

// ===== design/spcg_gate_sel.sv
// Per-port clock enable selection from the run, sleep and deep-sleep gating registers
`timescale 1ns/100ps
`default_nettype none
module spcg_gate_sel (
    // Gating registers in, enables out
    spcg_gate_if.sel gate
);
    // Sleep gating is honoured only with automatic gating on
    logic useSleep;
    // Deep-sleep gating is honoured only with automatic gating on
    logic useDeep;

    // Mode decode; without the flag sleep modes keep the run enables
    always_comb begin
        useSleep = gate.autoGate && (gate.mode == spcg_pkg::ModeSleep);
        useDeep = gate.autoGate && (gate.mode == spcg_pkg::ModeDeep);
    end

    // One selector per port unit
    for (genvar i = 0; i < spcg_pkg::NumPorts; i++) begin : gPort
        always_comb begin
            if (useDeep) begin
                gate.effEn[i] = gate.deepGate[i];
            end else if (useSleep) begin
                gate.effEn[i] = gate.sleepGate[i];
            end else begin
                gate.effEn[i] = gate.runGate[i];
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/spcg_top.sv
// Sleep port clock gating block with APB registers and bus fault checking
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Gating bit set clocks port, clear disables it
// - Port H at bit 7 down to A at 0
// - Access to unclocked port answers bus fault
// - Sleep gating register resets to all zero
// - Sleep register applies only during Sleep
// - Run register supplies enables while running
// - Deep-sleep register supplies enables in Deep-Sleep
// - Sleep registers used only with automatic flag
// - Bit positions without a port have no effect
module spcg_top (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System operating mode
    input wire logic [1:0] sysMode,
    // Port access requests, one pulse bit per port
    input wire logic [7:0] portReq,
    // Port clock enables and access answers
    output logic [7:0] portClkEn,
    output logic [7:0] portDone,
    output logic [7:0] portFault,
    // Interrupt
    output logic irq
);
    // Registered state and its next value
    spcg_pkg::spcg_state_t state_q;
    spcg_pkg::spcg_state_t state_d;
    // Link to the enable selector
    spcg_gate_if gateLink ();
    // Bus phase decodes
    logic setupPhase;
    logic accessPhase;
    logic wrAccess;
    // Address hits
    logic hitRun;
    logic hitSleep;
    logic hitDeep;
    logic hitCfg;
    logic hitStatus;
    logic hitMask;
    logic hitAny;
    // Port access outcomes this cycle
    logic [7:0] faultCause;
    logic [7:0] doneCause;
    // Mode in enum form
    spcg_pkg::spcg_mode_t modeNow;

    // Enable selector; it looks at the registered gate values and the unregistered sysMode
    spcg_gate_sel uSel (
        .gate(gateLink.sel)
    );

    // Feed the selector from current register state
    always_comb begin
        modeNow = spcg_pkg::spcg_mode_t'(sysMode);
        gateLink.runGate = state_q.runGate;
        gateLink.sleepGate = state_q.sleepGate;
        gateLink.deepGate = state_q.deepGate;
        gateLink.autoGate = state_q.autoGate;
        gateLink.mode = modeNow;
    end

    // APB phase and address decode
    always_comb begin
        setupPhase = psel && !penable;
        accessPhase = psel && penable;
        wrAccess = accessPhase && pwrite && ce;
        hitRun = (paddr == spcg_pkg::RunGateOffset);
        hitSleep = (paddr == spcg_pkg::SleepGateOffset);
        hitDeep = (paddr == spcg_pkg::DeepGateOffset);
        hitCfg = (paddr == spcg_pkg::ClockCfgOffset);
        hitStatus = (paddr == spcg_pkg::IrqStatusOffset);
        hitMask = (paddr == spcg_pkg::IrqMaskOffset);
        hitAny = hitRun || hitSleep || hitDeep || hitCfg || hitStatus || hitMask;
    end

    // Port accesses are judged against the enables the ports really have now
    always_comb begin
        faultCause = portReq & ~state_q.portClkEn;
        doneCause = portReq & state_q.portClkEn;
    end

    // Next-state logic for the whole block
    always_comb begin
        state_d = state_q;
        // Clock enables follow the selector one cycle later, glitch free
        state_d.portClkEn = gateLink.effEn;
        // Access answers last one cycle
        state_d.portFault = faultCause;
        state_d.portDone = doneCause;
        // Read data is fetched in the setup cycle so the access phase needs no wait
        if (setupPhase) begin
            state_d.readData = spcg_pkg::ReadZero;
            state_d.slvErr = !hitAny;
            if (hitRun) begin
                state_d.readData[7:0] = state_q.runGate;
            end else if (hitSleep) begin
                state_d.readData[7:0] = state_q.sleepGate;
            end else if (hitDeep) begin
                state_d.readData[7:0] = state_q.deepGate;
            end else if (hitCfg) begin
                state_d.readData[spcg_pkg::AutoGateBit] = state_q.autoGate;
            end else if (hitStatus) begin
                state_d.readData[7:0] = state_q.irqStatus;
            end else if (hitMask) begin
                state_d.readData[7:0] = state_q.irqMask;
            end else begin
                state_d.readData = spcg_pkg::ReadZero;
            end
        end
        // Register writes; bits 31 to 8 have no storage and drop silently
        if (wrAccess) begin
            if (hitRun) begin
                state_d.runGate = pwdata[spcg_pkg::PortHMsb:spcg_pkg::PortALsb];
            end
            if (hitSleep) begin
                state_d.sleepGate = pwdata[spcg_pkg::PortHMsb:spcg_pkg::PortALsb];
            end
            if (hitDeep) begin
                state_d.deepGate = pwdata[spcg_pkg::PortHMsb:spcg_pkg::PortALsb];
            end
            if (hitCfg) begin
                state_d.autoGate = pwdata[spcg_pkg::AutoGateBit];
            end
            if (hitMask) begin
                state_d.irqMask = pwdata[7:0];
            end
        end
        // Sticky fault status; a new fault wins over a clearing write
        if (wrAccess && hitStatus) begin
            state_d.irqStatus = (state_q.irqStatus & ~pwdata[7:0]) | faultCause;
        end else begin
            state_d.irqStatus = state_q.irqStatus | faultCause;
        end
    end

    // State register; reset overrides the clock enable so the block always starts clean
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q.runGate <= spcg_pkg::GateReset;
            state_q.sleepGate <= spcg_pkg::GateReset;
            state_q.deepGate <= spcg_pkg::GateReset;
            state_q.autoGate <= spcg_pkg::AutoGateReset;
            state_q.irqStatus <= spcg_pkg::IrqStatusReset;
            state_q.irqMask <= spcg_pkg::IrqMaskReset;
            state_q.readData <= spcg_pkg::ReadZero;
            state_q.slvErr <= 1'h0;
            state_q.portClkEn <= spcg_pkg::GateReset;
            state_q.portFault <= 8'h00;
            state_q.portDone <= 8'h00;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // Outputs; pready and pslverr are gated combinationally by the access phase, everything else comes from flops
    always_comb begin
        prdata = state_q.readData;
        pslverr = state_q.slvErr && accessPhase;
        pready = accessPhase && ce;
        portClkEn = state_q.portClkEn;
        portFault = state_q.portFault;
        portDone = state_q.portDone;
        irq = |(state_q.irqStatus & state_q.irqMask);
    end

    // Helper views for the checks below
    logic [7:0] runSeen;
    logic [7:0] sleepSeen;
    logic [7:0] deepSeen;
    logic [7:0] clkEnSeen;
    logic autoSeen;
    always_comb begin
        runSeen = state_q.runGate;
        sleepSeen = state_q.sleepGate;
        deepSeen = state_q.deepGate;
        clkEnSeen = state_q.portClkEn;
        autoSeen = state_q.autoGate;
    end

    // After reset the sleep gates and all port clocks are off
    a_reset_all_off: assert property (@(posedge clk)
        !rst_n |=> (sleepSeen == 8'h00) && (clkEnSeen == 8'h00) && (prdata[31:8] == 24'h000000))
        else $error("Gating not cleared by reset");

    // An access to an unclocked port faults next cycle, never together with a done
    a_fault_unclocked: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> (portFault == $past(faultCause)) && ((portFault & portDone) == 8'h00))
        else $error("Port fault does not match clock state");

    // A clocked port completes its access
    a_done_clocked: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && (doneCause != 8'h00)) |=> (portDone != 8'h00) && (portFault != 8'hff))
        else $error("Clocked port access did not complete");

    // Sleep with the flag set takes the sleep register
    a_sleep_select: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && (sysMode == spcg_pkg::ModeSleep) && autoSeen) |=> (clkEnSeen == $past(sleepSeen)))
        else $error("Sleep enables not applied");

    // Running takes the run register
    a_run_select: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && (sysMode == spcg_pkg::ModeRun)) |=> (clkEnSeen == $past(runSeen)))
        else $error("Run enables not applied");

    // Deep-Sleep with the flag set takes the deep-sleep register
    a_deep_select: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && (sysMode == spcg_pkg::ModeDeep) && autoSeen) |=> (clkEnSeen == $past(deepSeen)))
        else $error("Deep-sleep enables not applied");

    // Without the flag every mode keeps the run enables
    a_flag_off_run: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !autoSeen) |=> (clkEnSeen == $past(runSeen)))
        else $error("Sleep gating used with flag clear");

    // A write to the sleep register lands bit for bit in that register
    a_sleep_write_map: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAccess && hitSleep) |=> (sleepSeen == $past(pwdata[7:0])))
        else $error("Sleep register write misplaced");

    // Upper bits always read zero on a sleep register read
    a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && setupPhase && hitSleep && !pwrite) |=> (prdata[31:8] == 24'h000000)
            && (prdata[7:0] == $past(sleepSeen)))
        else $error("Sleep register read wrong");

    // Ports have no hidden state beyond bit 7, so the gate value fits the byte
    a_unused_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAccess && hitSleep && (pwdata[7:0] == 8'h00)) |=> (sleepSeen == 8'h00))
        else $error("Upper write bits leaked into gating");

    // Unmapped addresses answer with an error in the access phase
    a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && setupPhase && !hitAny) |=> (penable && psel) |-> pslverr)
        else $error("Unmapped address not refused");

    // A port fault sets its sticky status bit even under a clearing write
    a_fault_sticky_set: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && (faultCause != 8'h00)) |=> ((state_q.irqStatus & $past(faultCause))
            == $past(faultCause)))
        else $error("Port fault status not latched");

    // Clock enable low holds every register, bus and port state alike
    a_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ce |=> (state_q == $past(state_q)))
        else $error("State moved while clock enable low");
endmodule
`default_nettype wire

// ===== testbench/spcg_port_units.sv
// Behavioural model of the eight port units that sit behind the clock enables
`timescale 1ns/100ps
`default_nettype none
module spcg_port_units (
    // Clock
    input wire logic clk,
    // Enables and answers from the gating block
    input wire logic [7:0] portClkEn,
    input wire logic [7:0] portDone,
    input wire logic [7:0] portFault,
    // Access requests towards the gating block
    output logic [7:0] portReq
);
    // Requests idle low outside an access
    initial portReq = 8'h00;

    // One-cycle request pulse, then sample the one-cycle answer
    task automatic access(input logic [7:0] which, output logic [7:0] done,
                          output logic [7:0] fault, output logic [7:0] live);
        @(posedge clk);
        portReq <= which;
        live = portClkEn;
        @(posedge clk);
        portReq <= 8'h00;
        // Answers stand for one cycle only, so take them inside it
        #1;
        done = portDone;
        fault = portFault;
    endtask
endmodule
`default_nettype wire

// ===== testbench/sleep_port_clock_gating_tb_top.sv
// Self-checking testbench of the sleep port clock gating block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sleep_port_clock_gating_tb_top;
    // Clock, reset and bus
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Mode, ports and interrupt
    logic [1:0] sysMode = 2'b00;
    logic [7:0] portReq;
    logic [7:0] portClkEn;
    logic [7:0] portDone;
    logic [7:0] portFault;
    logic irq;
    // Counters
    int fails = 0;
    int testsRun = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    // Clock enable is driven so that the freeze can be exercised
    spcg_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysMode(sysMode), .portReq(portReq), .portClkEn(portClkEn),
        .portDone(portDone), .portFault(portFault), .irq(irq));

    // Port units on the far side
    spcg_port_units units (.clk(clk), .portClkEn(portClkEn), .portDone(portDone),
        .portFault(portFault), .portReq(portReq));

    // Verdict and end of run
    task automatic reportAndStop;
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            reportAndStop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write, expecting no error
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        `CHK(err, 1'b0)
    endtask

    // Register read compared against an expected word
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h00000000, rd, err);
        `CHK(rd, exp)
        `CHK(err, 1'b0)
    endtask

    // Let registered enables follow a register change, then settle
    task automatic pause;
        @(posedge clk);
        #2;
    endtask

    // Change the system mode and let the enables follow
    task automatic setMode(input logic [1:0] m);
        @(posedge clk);
        sysMode <= m;
        pause();
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        reportAndStop();
    end

    // Main sequence
    initial begin
        logic [7:0] done;
        logic [7:0] fault;
        logic [7:0] live;
        logic [31:0] rd;
        logic err;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        pause();
        `CHK(portClkEn, 8'h00)
        `CHK(irq, 1'b0)
        rdChk(spcg_pkg::SleepGateOffset, 32'h00000000);
        // Upper bits hold nothing; positions without a port change nothing
        wr(spcg_pkg::SleepGateOffset, 32'hffffffff);
        rdChk(spcg_pkg::SleepGateOffset, 32'h000000ff);
        wr(spcg_pkg::SleepGateOffset, 32'hffffff00);
        rdChk(spcg_pkg::SleepGateOffset, 32'h00000000);
        pause();
        `CHK(portClkEn, 8'h00)
        // Distinct patterns per mode register tell the sources apart
        wr(spcg_pkg::RunGateOffset, 32'h00000030);
        wr(spcg_pkg::DeepGateOffset, 32'h0000000c);
        pause();
        `CHK(portClkEn, 8'h30)
        wr(spcg_pkg::ClockCfgOffset, 32'h00000001);
        setMode(spcg_pkg::ModeSleep);
        // Walk a single enable from port A up to port H
        for (int i = 0; i < 8; i++) begin
            wr(spcg_pkg::SleepGateOffset, 32'h00000001 << i);
            pause();
            `CHK(portClkEn, 8'h01 << i)
        end
        wr(spcg_pkg::ClockCfgOffset, 32'h00000000);
        pause();
        `CHK(portClkEn, 8'h30)
        wr(spcg_pkg::ClockCfgOffset, 32'h00000001);
        setMode(spcg_pkg::ModeDeep);
        `CHK(portClkEn, 8'h0c)
        setMode(spcg_pkg::ModeSleep);
        // Software enables ports A and C before touching them
        wr(spcg_pkg::SleepGateOffset, 32'h00000005);
        pause();
        units.access(8'hff, done, fault, live);
        `CHK(live, 8'h05)
        `CHK(done, 8'h05)
        `CHK(fault, 8'hfa)
        // Faults are latched as sticky events
        rdChk(spcg_pkg::IrqStatusOffset, 32'h000000fa);
        `CHK(irq, 1'b0)
        wr(spcg_pkg::IrqMaskOffset, 32'h00000002);
        pause();
        `CHK(irq, 1'b1)
        wr(spcg_pkg::IrqStatusOffset, 32'h00000002);
        pause();
        `CHK(irq, 1'b0)
        rdChk(spcg_pkg::IrqStatusOffset, 32'h000000f8);
        // Clock enable low freezes all state: no mode change, no port answer
        @(posedge clk);
        ce <= 1'b0;
        sysMode <= 2'b11;
        units.access(8'hff, done, fault, live);
        `CHK(portClkEn, 8'h05)
        `CHK(fault, 8'h00)
        `CHK(done, 8'h00)
        // Code 11 counts as running once the clock enable returns
        @(posedge clk);
        ce <= 1'b1;
        pause();
        `CHK(portClkEn, 8'h30)
        rdChk(spcg_pkg::IrqStatusOffset, 32'h000000f8);
        // Unmapped address answers with an error and zero data
        apb(1'b0, 12'h200, 32'h00000000, rd, err);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
        reportAndStop();
    end
endmodule
`undef CHK
`default_nettype wire
